/* uesev_pkg.sv */
// Constants for the uncorrectable error severity register.
package uesev_pkg;

	// ==========================================================
	// Register placement and layout
	localparam logic [11:0] UESEV_OFFSET      = 12'h10C;
	localparam logic [31:0] UESEV_RESET       = 32'h0006_2031;
	localparam logic [31:0] UESEV_RW_MASK     = 32'h001F_F010;
	localparam logic [31:0] UESEV_FIXED_ONES  = 32'h0000_0021;
	localparam logic [31:0] UESEV_RSVD_HI     = 32'hFFC0_0000;
	localparam logic [31:0] UESEV_RSVD_MID    = 32'h0000_0FC0;
	localparam logic [31:0] UESEV_RSVD_LO     = 32'h0000_000E;

	// ==========================================================
	// Field positions
	localparam int UESEV_ACCESS_VIOLATION_BIT = 21;
	localparam int UESEV_UNSUPPORTED_REQ_BIT  = 20;
	localparam int UESEV_END_TO_END_CRC_BIT   = 19;
	localparam int UESEV_MALFORMED_BIT        = 18;
	localparam int UESEV_RX_OVERFLOW_BIT      = 17;
	localparam int UESEV_UNEXP_CPL_BIT        = 16;
	localparam int UESEV_CPL_ABORT_BIT        = 15;
	localparam int UESEV_CPL_TIMEOUT_BIT      = 14;
	localparam int UESEV_FLOW_CONTROL_BIT     = 13;
	localparam int UESEV_POISONED_BIT         = 12;
	localparam int UESEV_SURPRISE_DOWN_BIT    = 5;
	localparam int UESEV_LINK_PROTOCOL_BIT    = 4;

	// ==========================================================
	// Values after reset of the block's own flip-flops
	localparam logic        UESEV_SYNC_RESET  = 1'b1;
	localparam logic [31:0] UESEV_RDATA_RESET = 32'h0000_0000;

	typedef struct packed {
		logic [31:0] severity;
		logic        link_rst_s1;
		logic        link_rst_s2;
		logic        global_rst_s1;
		logic        global_rst_s2;
		logic [31:0] rdata;
		logic        rd_valid;
		logic        fatal_msg;
		logic        nonfatal_msg;
	} uesev_state_type;

endpackage

/* uesev_regs.sv */
// Uncorrectable error severity register and fatal/nonfatal message selection.
`timescale 1ns/1ps

// Notes on behaviour
// - Unmasked error with severity 1 raises the fatal message pulse.
// - Unmasked error with severity 0 raises the nonfatal message pulse.
// - Register sits at extended offset 10Ch, resets to 0006_2031h.
// - Bit 20 unsupported-request severity, read/write, resets to 0.
// - Bit 19 end-to-end CRC severity, read/write, resets to 0.
// - Bit 13 flow-control severity, read/write, resets to 1.
// - Bit 4 link-protocol severity, read/write, resets to 1.
// - Bits 18..14 and 12 read/write; 18 and 17 reset to 1, rest 0.
// - Bit 21 access-violation severity is read-only zero.
// - Bit 5 surprise-down severity is read-only one.
// - Bit 0 is reserved and reads one.
// - Bits 31..22 are reserved and read zero.
// - Bits 11..6 are reserved and read zero.
// - Bits 3..1 are reserved and read zero.
// - Link reset, global reset or power-on reset restores the defaults.
// - A masked error sends no message whatever its severity.
module uesev_regs
	import uesev_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        link_reset_n,
	input  wire logic        global_reset_input_n,
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [11:0] cfg_addr,
	input  wire logic [31:0] cfg_wdata,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] error_detected,
	input  wire logic [31:0] error_mask,
	output logic      [31:0] cfg_rdata,
	output logic             cfg_rd_valid,
	output logic      [31:0] severity,
	output logic             err_fatal_msg,
	output logic             err_nonfatal_msg
);

	uesev_state_type state_q;
	uesev_state_type state_d;

	// ==========================================================
	// Timing seen from the configuration side
	// A write is taken on the edge where cfg_wr is high and the word address
	// matches; the new value shows on severity one cycle later.
	// A read is taken on any edge with cfg_rd high; cfg_rd_valid and cfg_rdata
	// stand for exactly one cycle after it, and an unmapped offset reads zero.
	// A read in the same cycle as a write returns the old value, so software
	// that must see its own write has to issue the read on a later edge.
	// Byte enables merge lanes; lane 3 holds only reserved bits and is ignored.
	// Error events are classified against the severity value that stood before
	// any write of the same cycle, so a write never splits one event in two.
	// Both message requests may rise together when events of both classes meet.
	// The link and global reset pins are asynchronous; each passes two flops,
	// so the defaults take hold three edges after a pin falls and stay for two
	// edges after it rises. Writes in that span are lost on purpose, so that a
	// half-written severity never survives a reset of the link.

	// ==========================================================
	// Access decode and reset qualifiers
	logic        hit;
	logic        wr_hit;
	logic        rd_hit;
	logic        pin_reset;
	logic        lane0_wr;
	logic        lane1_wr;
	logic        lane2_wr;
	logic [31:0] assembled;

	// ==========================================================
	// Per-field next values
	logic        access_violation_severity;
	logic        unsupported_request_severity;
	logic        end_to_end_crc_severity;
	logic        malformed_packet_severity;
	logic        receiver_overflow_severity;
	logic        unexpected_completion_severity;
	logic        completer_abort_severity;
	logic        completion_timeout_severity;
	logic        flow_control_severity;
	logic        poisoned_packet_severity;
	logic        surprise_down_severity;
	logic        link_protocol_severity;

	// ==========================================================
	// Per-error events that survive the mask
	logic        rep_unsupported_request;
	logic        rep_end_to_end_crc;
	logic        rep_malformed_packet;
	logic        rep_receiver_overflow;
	logic        rep_unexpected_completion;
	logic        rep_completer_abort;
	logic        rep_completion_timeout;
	logic        rep_flow_control;
	logic        rep_poisoned_packet;
	logic        rep_link_protocol;
	logic [31:0] reported;
	logic [31:0] fatal_hits;
	logic [31:0] nonfatal_hits;

	// ==========================================================
	// Next state
	always_comb begin
		state_d = state_q;

		// Both reset pins come from outside the clock domain.
		state_d.link_rst_s1   = link_reset_n;
		state_d.link_rst_s2   = state_q.link_rst_s1;
		state_d.global_rst_s1 = global_reset_input_n;
		state_d.global_rst_s2 = state_q.global_rst_s1;
		// Either pin, once synchronised, holds the defaults and overrides writes.
		pin_reset = !state_q.link_rst_s2 || !state_q.global_rst_s2;

		// Low two address bits are ignored by the decode; byte enables pick the lanes.
		hit      = (cfg_addr[11:2] == UESEV_OFFSET[11:2]);
		wr_hit   = cfg_wr && hit;
		rd_hit   = cfg_rd && hit;
		lane0_wr = wr_hit && cfg_be[0];
		lane1_wr = wr_hit && cfg_be[1];
		lane2_wr = wr_hit && cfg_be[2];

		// Unsupported positions are constants, so writes cannot reach them.
		access_violation_severity = 1'h0;
		surprise_down_severity    = 1'h1;

		// Unsupported request severity sits in byte lane 2.
		unsupported_request_severity = state_q.severity[UESEV_UNSUPPORTED_REQ_BIT];
		if (lane2_wr) begin
			unsupported_request_severity = cfg_wdata[UESEV_UNSUPPORTED_REQ_BIT];
		end

		// End-to-end CRC severity sits in byte lane 2.
		end_to_end_crc_severity = state_q.severity[UESEV_END_TO_END_CRC_BIT];
		if (lane2_wr) begin
			end_to_end_crc_severity = cfg_wdata[UESEV_END_TO_END_CRC_BIT];
		end

		// Malformed packet severity sits in byte lane 2.
		malformed_packet_severity = state_q.severity[UESEV_MALFORMED_BIT];
		if (lane2_wr) begin
			malformed_packet_severity = cfg_wdata[UESEV_MALFORMED_BIT];
		end

		// Receiver overflow severity sits in byte lane 2.
		receiver_overflow_severity = state_q.severity[UESEV_RX_OVERFLOW_BIT];
		if (lane2_wr) begin
			receiver_overflow_severity = cfg_wdata[UESEV_RX_OVERFLOW_BIT];
		end

		// Unexpected completion severity sits in byte lane 2.
		unexpected_completion_severity = state_q.severity[UESEV_UNEXP_CPL_BIT];
		if (lane2_wr) begin
			unexpected_completion_severity = cfg_wdata[UESEV_UNEXP_CPL_BIT];
		end

		// Completer abort severity sits in byte lane 1.
		completer_abort_severity = state_q.severity[UESEV_CPL_ABORT_BIT];
		if (lane1_wr) begin
			completer_abort_severity = cfg_wdata[UESEV_CPL_ABORT_BIT];
		end

		// Completion timeout severity sits in byte lane 1.
		completion_timeout_severity = state_q.severity[UESEV_CPL_TIMEOUT_BIT];
		if (lane1_wr) begin
			completion_timeout_severity = cfg_wdata[UESEV_CPL_TIMEOUT_BIT];
		end

		// Flow-control severity sits in byte lane 1.
		flow_control_severity = state_q.severity[UESEV_FLOW_CONTROL_BIT];
		if (lane1_wr) begin
			flow_control_severity = cfg_wdata[UESEV_FLOW_CONTROL_BIT];
		end

		// Poisoned packet severity sits in byte lane 1.
		poisoned_packet_severity = state_q.severity[UESEV_POISONED_BIT];
		if (lane1_wr) begin
			poisoned_packet_severity = cfg_wdata[UESEV_POISONED_BIT];
		end

		// Link-protocol severity sits in byte lane 0.
		link_protocol_severity = state_q.severity[UESEV_LINK_PROTOCOL_BIT];
		if (lane0_wr) begin
			link_protocol_severity = cfg_wdata[UESEV_LINK_PROTOCOL_BIT];
		end

		// Reserved fields come from constants, so no write can set them.
		assembled = {
			10'h000,
			access_violation_severity,
			unsupported_request_severity,
			end_to_end_crc_severity,
			malformed_packet_severity,
			receiver_overflow_severity,
			unexpected_completion_severity,
			completer_abort_severity,
			completion_timeout_severity,
			flow_control_severity,
			poisoned_packet_severity,
			6'h00,
			surprise_down_severity,
			link_protocol_severity,
			3'h0,
			1'h1
		};
		state_d.severity = assembled;
		if (pin_reset) begin
			state_d.severity = UESEV_RESET;
		end

		// Reads answer one cycle later; an unmapped offset reads zero.
		state_d.rd_valid = cfg_rd;
		if (rd_hit) begin
			state_d.rdata = state_q.severity;
		end else begin
			state_d.rdata = UESEV_RDATA_RESET;
		end

		// Surprise down is not detected by this bridge, so its fixed severity
		// never produces a message; only the ten supported errors are classified.
		rep_unsupported_request = error_detected[UESEV_UNSUPPORTED_REQ_BIT]
			&& !error_mask[UESEV_UNSUPPORTED_REQ_BIT];

		rep_end_to_end_crc = error_detected[UESEV_END_TO_END_CRC_BIT]
			&& !error_mask[UESEV_END_TO_END_CRC_BIT];

		rep_malformed_packet = error_detected[UESEV_MALFORMED_BIT]
			&& !error_mask[UESEV_MALFORMED_BIT];

		rep_receiver_overflow = error_detected[UESEV_RX_OVERFLOW_BIT]
			&& !error_mask[UESEV_RX_OVERFLOW_BIT];

		rep_unexpected_completion = error_detected[UESEV_UNEXP_CPL_BIT]
			&& !error_mask[UESEV_UNEXP_CPL_BIT];

		rep_completer_abort = error_detected[UESEV_CPL_ABORT_BIT]
			&& !error_mask[UESEV_CPL_ABORT_BIT];

		rep_completion_timeout = error_detected[UESEV_CPL_TIMEOUT_BIT]
			&& !error_mask[UESEV_CPL_TIMEOUT_BIT];

		rep_flow_control = error_detected[UESEV_FLOW_CONTROL_BIT]
			&& !error_mask[UESEV_FLOW_CONTROL_BIT];

		rep_poisoned_packet = error_detected[UESEV_POISONED_BIT]
			&& !error_mask[UESEV_POISONED_BIT];

		rep_link_protocol = error_detected[UESEV_LINK_PROTOCOL_BIT]
			&& !error_mask[UESEV_LINK_PROTOCOL_BIT];

		// Reserved and unsupported positions never report.
		reported = {
			10'h000,
			1'h0,
			rep_unsupported_request,
			rep_end_to_end_crc,
			rep_malformed_packet,
			rep_receiver_overflow,
			rep_unexpected_completion,
			rep_completer_abort,
			rep_completion_timeout,
			rep_flow_control,
			rep_poisoned_packet,
			6'h00,
			1'h0,
			rep_link_protocol,
			3'h0,
			1'h0
		};
		fatal_hits    = reported & state_q.severity;
		nonfatal_hits = reported & ~state_q.severity;
		state_d.fatal_msg    = |fatal_hits;
		state_d.nonfatal_msg = |nonfatal_hits;
	end

	// ==========================================================
	// State register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q.severity     <= UESEV_RESET;
			state_q.link_rst_s1  <= UESEV_SYNC_RESET;
			state_q.link_rst_s2  <= UESEV_SYNC_RESET;
			state_q.global_rst_s1 <= UESEV_SYNC_RESET;
			state_q.global_rst_s2 <= UESEV_SYNC_RESET;
			state_q.rdata        <= UESEV_RDATA_RESET;
			state_q.rd_valid     <= 1'b0;
			state_q.fatal_msg    <= 1'b0;
			state_q.nonfatal_msg <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	assign cfg_rdata        = state_q.rdata;
	assign cfg_rd_valid     = state_q.rd_valid;
	assign severity         = state_q.severity;
	assign err_fatal_msg    = state_q.fatal_msg;
	assign err_nonfatal_msg = state_q.nonfatal_msg;

endmodule

/* uesev_sva.sv */
// Port checker for the severity register.
`timescale 1ns/1ps
module uesev_sva import uesev_pkg::*; (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        link_reset_n,
	input wire logic        global_reset_input_n,
	input wire logic        cfg_wr,
	input wire logic        cfg_rd,
	input wire logic        cfg_rd_valid,
	input wire logic        err_fatal_msg,
	input wire logic        err_nonfatal_msg,
	input wire logic [11:0] cfg_addr,
	input wire logic [3:0]  cfg_be,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] error_detected,
	input wire logic [31:0] error_mask,
	input wire logic [31:0] cfg_rdata,
	input wire logic [31:0] severity
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire logic [31:0] rep = error_detected & ~error_mask & UESEV_RW_MASK;
	wire logic        hit = cfg_addr[11:2] == UESEV_OFFSET[11:2];
	// Pins high four cycles so that no synchronised reset is still forcing.
	sequence s_calm; (link_reset_n && global_reset_input_n) [*4]; endsequence
	sequence s_put; cfg_wr && hit && cfg_be == 4'hF; endsequence
	property p_fat; |(rep & severity) |=> err_fatal_msg; endproperty
	property p_nf; |(rep & ~severity) |=> err_nonfatal_msg; endproperty
	property p_quiet; rep == '0 |=> !err_fatal_msg && !err_nonfatal_msg; endproperty
	property p_fix; (severity & ~UESEV_RW_MASK) == UESEV_FIXED_ONES; endproperty
	property p_rdv; cfg_rd |=> cfg_rd_valid; endproperty
	property p_rd; cfg_rd && hit |=> cfg_rdata == $past(severity); endproperty
	property p_wr;
		s_calm ##0 s_put |=> severity == (($past(cfg_wdata) & UESEV_RW_MASK) | UESEV_FIXED_ONES);
	endproperty
	property p_lrst; (!link_reset_n) [*3] |=> severity == UESEV_RESET; endproperty
	a_fat: assert property (p_fat) else $error("fatal missing");
	a_nf: assert property (p_nf) else $error("nonfatal missing");
	a_quiet: assert property (p_quiet) else $error("stray message");
	a_fix: assert property (p_fix) else $error("fixed bits");
	a_rdv: assert property (p_rdv) else $error("no read answer");
	a_rd: assert property (p_rd) else $error("read data");
	a_wr: assert property (p_wr) else $error("write merge");
	a_lrst: assert property (p_lrst) else $error("link reset");
endmodule
bind uesev_regs uesev_sva u_sva(.*);

/* uesev_host.sv */
// Root complex model issuing configuration accesses.
`timescale 1ns/1ps
module uesev_host(
	input wire logic        sys_clk,
	output logic            wr,
	output logic            rd,
	output logic [11:0]     addr,
	output logic [31:0]     wdata,
	output logic [3:0]      be,
	input wire logic [31:0] rdata
);
	initial {wr, rd, addr, wdata, be} = '0;
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge sys_clk) #1;
		{wr, rd, addr, wdata, be} = {w, !w, a, d, 4'hF};
		@(posedge sys_clk) #1;
		q = rdata;
		// Released lines are scrambled so stale values are never trusted.
		{wr, rd, addr, wdata} = {2'b00, ~addr, ~wdata};
	endtask
endmodule

/* uesev_regs_tb.sv */
// Self-checking bench for the severity register.
`timescale 1ns/1ps
module uesev_regs_tb;
	import uesev_pkg::*;
	logic        sys_clk = 0, rst_n = 0, lr_n = 1, gr_n = 1, wr, rd, fat, nf, rdv;
	logic [11:0] addr;
	logic [31:0] wd, rdat, sev, det = '0, msk = '0, q;
	logic [3:0]  be;
	int          mismatches = 0, checks = 0;
	always #5 sys_clk = ~sys_clk;
	uesev_host u_host(.sys_clk(sys_clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wd),
		.be(be), .rdata(rdat));
	uesev_regs u_dut(.sys_clk(sys_clk), .rst_n(rst_n), .link_reset_n(lr_n),
		.global_reset_input_n(gr_n), .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(addr),
		.cfg_wdata(wd), .cfg_be(be), .error_detected(det), .error_mask(msk),
		.cfg_rdata(rdat), .cfg_rd_valid(rdv), .severity(sev), .err_fatal_msg(fat),
		.err_nonfatal_msg(nf));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s exp %h saw %h", n, e, s);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic ev(input int b, input logic [1:0] e);
		@(posedge sys_clk) #1 det = 32'h1 << b;
		@(posedge sys_clk) #1 det = '0;
		chk("msg", {fat, nf}, e);
	endtask
	initial begin
		#20000 mismatches++;
		print_verdict();
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		#1 rst_n = 1;
		u_host.acc(1'b0, 12'h10C, '0, q);
		chk("reset", q, 32'h0006_2031);
		chk("valid", rdv, 32'h1);
		chk("severity", sev, 32'h0006_2031);
		u_host.acc(1'b0, 12'h108, '0, q);
		chk("unmapped", q, 32'h0);
		u_host.acc(1'b1, 12'h10C, '0, q);
		u_host.acc(1'b0, 12'h10C, '0, q);
		chk("zeros", q, 32'h0000_0021);
		for (int b = 0; b < 22; b++) ev(b, {1'b0, UESEV_RW_MASK[b]});
		u_host.acc(1'b1, 12'h10C, 32'hFFFF_FFFF, q);
		u_host.acc(1'b0, 12'h10C, '0, q);
		chk("ones", q, 32'h001F_F031);
		for (int b = 0; b < 22; b++) ev(b, {UESEV_RW_MASK[b], 1'b0});
		msk = '1;
		ev(13, 2'b00);
		msk = '0;
		for (int k = 0; k < 2; k++) begin
			u_host.acc(1'b1, 12'h10C, '0, q);
			{lr_n, gr_n} = k ? 2'b10 : 2'b01;
			repeat (5) @(posedge sys_clk);
			#1 {lr_n, gr_n} = 2'b11;
			repeat (3) @(posedge sys_clk);
			u_host.acc(1'b0, 12'h10C, '0, q);
			chk("pin reset", q, 32'h0006_2031);
		end
		print_verdict();
	end
endmodule
